/* File: hw/mcrb_regs.svh */
// register offsets, field positions and nonvolatile image values of the config bank
`ifndef MCRB_REGS_SVH
`define MCRB_REGS_SVH

`define MCRB_FACTORY_LAST        8'h05
`define MCRB_USER_WORD6          8'h06
`define MCRB_USER_WORD7          8'h07
`define MCRB_FACTORY_LOCK31      8'h1f
`define MCRB_SHADOW_OFFSET       8'h40
`define MCRB_FIRST_SHADOWED_NV   8'h08
`define MCRB_SPEED_INPUT_CONFIG  8'h48
`define MCRB_STARTUP_ACCEL       8'h49
`define MCRB_CURRENT_CONFIG      8'h4a
`define MCRB_STARTUP_PROTECT     8'h4b
`define MCRB_TUNING_OBSERVER     8'h4c
`define MCRB_SHADOW_COUNT        5

`define MCRB_WIDE_MASK           17'h1ffff
`define MCRB_WORD_MASK           17'h0ffff

`define MCRB_BAND_BIT            15
`define MCRB_PHASE_BIT           14
`define MCRB_ACCEL_RANGE_BIT     13
`define MCRB_DEMAND_CLK_HI       12
`define MCRB_DEMAND_CLK_LO       11
`define MCRB_MAX_SPEED_HI        10
`define MCRB_START_CUR_HI        15
`define MCRB_START_CUR_LO        13
`define MCRB_ANALOG_BIT          11
`define MCRB_RATED_CUR_HI        10
`define MCRB_METHOD_HI           11
`define MCRB_METHOD_LO           10
`define MCRB_LIMIT_BIT           7
`define MCRB_GUARD_BIT           4
`define MCRB_OPEN_DRIVE_BIT      3
`define MCRB_TUNE_BIT            16
`define MCRB_GAIN_HI             4

`define MCRB_NV0_RST             17'h00000
`define MCRB_NV1_RST             17'h00000
`define MCRB_NV2_RST             17'h00000
`define MCRB_NV3_RST             17'h00000
`define MCRB_NV4_RST             17'h00000
`define MCRB_NV5_RST             17'h00000
`define MCRB_NV6_RST             17'h00000
`define MCRB_NV7_RST             17'h00000
`define MCRB_NV8_RST             17'h00000
`define MCRB_NV9_RST             17'h00000
`define MCRB_NV10_RST            17'h02000
`define MCRB_NV11_RST            17'h00080
`define MCRB_NV12_RST            17'h00000

`endif

/* File: hw/mcrb_pkg.sv */
// types shared by the motor config register bank
package mcrb_pkg;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_REG,
      ST_REG_ACK,
      ST_WR,
      ST_WR_ACK,
      ST_RD_BIT,
      ST_RD_ACK,
      ST_RD_NEXT
   } mcrb_state_e;

   typedef struct packed {
      logic        pulse_input_band_sel;
      logic        phase_seq_abc;
      logic        accel_fine_range;
      logic [1:0]  demand_clock_source;
      logic [10:0] max_app_speed;
      logic [15:0] startup_accel;
      logic [2:0]  startup_current;
      logic        demand_input_kind;
      logic [10:0] rated_current;
      logic [1:0]  startup_method;
      logic        limit_and_buffer_enable;
      logic        missing_phase_guard;
      logic        open_loop_drive;
      logic        tuning_window_open;
      logic [4:0]  observer_prop_gain;
   } mcrb_cfg_s;

endpackage

/* File: hw/mcrb_top.sv */
// motor config register bank: two-wire serial target with shadow configuration words
//
// Overview of operation
// - acked last byte makes the next register's top byte follow at once.
// - burst read keeps stepping to higher addresses until the host nacks.
// - each shadow register sits at its nonvolatile word address plus 64.
// - words 0 to 5 and 31 are locked; writes to them are dropped.
// - words 6 and 7 are free user storage with no shadow copy.
// - register 72 bit 15 picks the input pulse frequency band.
// - register 72 bit 14 sets the phase sequence.
// - register 72 bit 13 scales the startup acceleration range.
// - register 72 bits 12:11 select the digital demand source.
// - register 72 bits 10:0 hold the maximum application speed.
// - register 74 bits 15:13 set the startup current limit in eighths.
// - register 74 bit 11 picks analog or digital demand input.
// - register 74 bits 10:0 hold the rated current.
// - register 75 bits 11:10 select the startup method.
// - register 75 bit 7 enables current limit and slew buffers.
// - register 75 bit 4 enables missing phase protection.
// - register 75 bit 3 forces open loop drive at rated speed.
// - register 76 bit 16 opens the inductance tuning window.
// - register 76 bits 4:0 hold the observer proportional gain.
// - write is address, register byte, three data bytes top first, stop.
// - shadows load from the nonvolatile image at power up; writes are volatile.
// - the target answers one fixed seven bit bus address.
`timescale 1ns/100ps
`default_nettype none
`include "mcrb_regs.svh"

module mcrb_top #(
   // value is arbitrary
   parameter logic [6:0] DEV_ADDR = 7'h2a
) (
   input  wire logic                clk_in,
   input  wire logic                rstn_in,
   input  wire logic                scl_in,
   input  wire logic                sda_in,
   output var  logic                sda_out,
   output var  logic                sda_oe_out,
   output var  logic                loaded_out,
   output var  mcrb_pkg::mcrb_cfg_s cfg_out
);
   import mcrb_pkg::*;

   // pin synchronisers: stage 0 feeds stage 1 only, stage 2 is the previous sample
   logic [2:0] scl_sync_ff;
   logic [2:0] sda_sync_ff;
   logic [2:0] nxt_scl_sync;
   logic [2:0] nxt_sda_sync;
   logic       scl_s;
   logic       sda_s;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_seen;
   logic       stop_seen;

   always_comb begin
      nxt_scl_sync = {scl_sync_ff[1:0], scl_in};
      nxt_sda_sync = {sda_sync_ff[1:0], sda_in};
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         scl_sync_ff <= 3'h7;
         sda_sync_ff <= 3'h7;
      end else begin
         scl_sync_ff <= nxt_scl_sync;
         sda_sync_ff <= nxt_sda_sync;
      end
   end

   assign scl_s      = scl_sync_ff[1];
   assign sda_s      = sda_sync_ff[1];
   assign scl_rise   = scl_s & ~scl_sync_ff[2];
   assign scl_fall   = ~scl_s & scl_sync_ff[2];
   assign start_seen = scl_s & scl_sync_ff[2] & sda_sync_ff[2] & ~sda_s;
   assign stop_seen  = scl_s & scl_sync_ff[2] & ~sda_sync_ff[2] & sda_s;

   // protocol and storage state
   mcrb_state_e state_ff;
   mcrb_state_e nxt_state;
   logic [3:0]  bit_cnt_ff;
   logic [3:0]  nxt_bit_cnt;
   logic [7:0]  shift_ff;
   logic [7:0]  nxt_shift;
   logic [1:0]  byte_idx_ff;
   logic [1:0]  nxt_byte_idx;
   logic [7:0]  ptr_ff;
   logic [7:0]  nxt_ptr;
   logic        rw_ff;
   logic        nxt_rw;
   logic [15:0] wdata_ff;
   logic [15:0] nxt_wdata;
   logic [23:0] out_word_ff;
   logic [23:0] nxt_out_word;
   logic        drive_low_ff;
   logic        nxt_drive_low;
   logic        loaded_ff;
   logic        nxt_loaded;
   logic [16:0] shadow_ff [0:`MCRB_SHADOW_COUNT-1];
   logic [16:0] nxt_shadow [0:`MCRB_SHADOW_COUNT-1];
   logic [15:0] user_ff [0:1];
   logic [15:0] nxt_user [0:1];
   logic [23:0] cur_word;
   logic [23:0] next_word;
   logic [7:0]  ptr_inc;
   logic [23:0] wr_word;

   // nonvolatile image; factory words never change, so they need no storage
   function automatic logic [16:0] nv_image(input logic [3:0] idx);
      case (idx)
         4'h0:    nv_image = `MCRB_NV0_RST;
         4'h1:    nv_image = `MCRB_NV1_RST;
         4'h2:    nv_image = `MCRB_NV2_RST;
         4'h3:    nv_image = `MCRB_NV3_RST;
         4'h4:    nv_image = `MCRB_NV4_RST;
         4'h5:    nv_image = `MCRB_NV5_RST;
         4'h6:    nv_image = `MCRB_NV6_RST;
         4'h7:    nv_image = `MCRB_NV7_RST;
         4'h8:    nv_image = `MCRB_NV8_RST;
         4'h9:    nv_image = `MCRB_NV9_RST;
         4'ha:    nv_image = `MCRB_NV10_RST;
         4'hb:    nv_image = `MCRB_NV11_RST;
         4'hc:    nv_image = `MCRB_NV12_RST;
         default: nv_image = 17'h00000;
      endcase
   endfunction

   function automatic logic is_shadow(input logic [7:0] a);
      is_shadow = (a >= `MCRB_SPEED_INPUT_CONFIG) && (a <= `MCRB_TUNING_OBSERVER);
   endfunction

   function automatic logic [2:0] shadow_idx(input logic [7:0] a);
      logic [7:0] d;
      d = a - `MCRB_SPEED_INPUT_CONFIG;
      shadow_idx = d[2:0];
   endfunction

   function automatic logic [16:0] width_mask(input logic [7:0] a);
      width_mask = (a == `MCRB_TUNING_OBSERVER) ? `MCRB_WIDE_MASK : `MCRB_WORD_MASK;
   endfunction

   function automatic logic is_factory(input logic [7:0] a);
      is_factory = (a <= `MCRB_FACTORY_LAST) || (a == `MCRB_FACTORY_LOCK31);
   endfunction

   // unmapped addresses, including 64 to 71 which have no shadow, read as zero
   function automatic logic [23:0] rd_word(input logic [7:0] a);
      rd_word = 24'h000000;
      if (a <= `MCRB_FACTORY_LAST)
         rd_word = {7'h00, nv_image(a[3:0])};
      else if (a == `MCRB_USER_WORD6 || a == `MCRB_USER_WORD7)
         rd_word = {8'h00, user_ff[a[0]]};
      else if (is_shadow(a))
         rd_word = {7'h00, shadow_ff[shadow_idx(a)] & width_mask(a)};
   endfunction

   function automatic logic [7:0] pick_byte(input logic [23:0] w, input logic [1:0] i);
      case (i)
         2'd0:    pick_byte = w[23:16];
         2'd1:    pick_byte = w[15:8];
         default: pick_byte = w[7:0];
      endcase
   endfunction

   // a process, not assigns: the read functions look at storage that is not an argument
   always_comb begin
      ptr_inc   = ptr_ff + 8'h01;
      cur_word  = rd_word(ptr_ff);
      next_word = rd_word(ptr_inc);
   end
   assign wr_word   = {wdata_ff, shift_ff};

   always_comb begin
      nxt_state     = state_ff;
      nxt_bit_cnt   = bit_cnt_ff;
      nxt_shift     = shift_ff;
      nxt_byte_idx  = byte_idx_ff;
      nxt_ptr       = ptr_ff;
      nxt_rw        = rw_ff;
      nxt_wdata     = wdata_ff;
      nxt_out_word  = out_word_ff;
      nxt_drive_low = drive_low_ff;
      nxt_loaded    = 1'b1;
      for (int i = 0; i < `MCRB_SHADOW_COUNT; i++) begin
         nxt_shadow[i] = shadow_ff[i];
         if (!loaded_ff)
            nxt_shadow[i] = nv_image(4'(i + 8));
      end
      nxt_user[0] = user_ff[0];
      nxt_user[1] = user_ff[1];

      if (!loaded_ff) begin
         nxt_state     = ST_IDLE;
      end else if (stop_seen) begin
         nxt_state     = ST_IDLE;
         nxt_drive_low = 1'b0;
      end else if (start_seen) begin
         nxt_state     = ST_ADDR;
         nxt_bit_cnt   = 4'h0;
         nxt_drive_low = 1'b0;
      end else begin
         case (state_ff)
            ST_ADDR, ST_REG, ST_WR: begin
               if (scl_rise) begin
                  nxt_shift   = {shift_ff[6:0], sda_s};
                  nxt_bit_cnt = bit_cnt_ff + 4'h1;
               end else if (scl_fall && bit_cnt_ff == 4'h8) begin
                  nxt_bit_cnt   = 4'h0;
                  nxt_drive_low = 1'b1;
                  if (state_ff == ST_ADDR) begin
                     if (shift_ff[7:1] == DEV_ADDR) begin
                        nxt_rw    = shift_ff[0];
                        nxt_state = ST_ADDR_ACK;
                     end else begin
                        nxt_drive_low = 1'b0;
                        nxt_state     = ST_IDLE;
                     end
                  end else if (state_ff == ST_REG) begin
                     nxt_ptr      = shift_ff;
                     nxt_byte_idx = 2'd0;
                     nxt_state    = ST_REG_ACK;
                  end else if (byte_idx_ff == 2'd3) begin
                     // a fourth data byte is refused
                     nxt_drive_low = 1'b0;
                     nxt_state     = ST_IDLE;
                  end else begin
                     nxt_wdata    = {wdata_ff[7:0], shift_ff};
                     nxt_byte_idx = byte_idx_ff + 2'd1;
                     nxt_state    = ST_WR_ACK;
                     if (byte_idx_ff == 2'd2) begin
                        // third byte completes the word; takes effect at once
                        if (is_shadow(ptr_ff))
                           nxt_shadow[shadow_idx(ptr_ff)] =
                              wr_word[16:0] & width_mask(ptr_ff);
                        else if (ptr_ff == `MCRB_USER_WORD6 || ptr_ff == `MCRB_USER_WORD7)
                           nxt_user[ptr_ff[0]] = wr_word[15:0];
                        else if (is_factory(ptr_ff))
                           nxt_state = ST_WR_ACK;
                     end
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (scl_fall) begin
                  if (rw_ff) begin
                     nxt_byte_idx  = 2'd0;
                     nxt_out_word  = cur_word;
                     nxt_shift     = cur_word[23:16];
                     nxt_drive_low = ~cur_word[23];
                     nxt_bit_cnt   = 4'h1;
                     nxt_state     = ST_RD_BIT;
                  end else begin
                     nxt_drive_low = 1'b0;
                     nxt_state     = ST_REG;
                  end
               end
            end
            ST_REG_ACK, ST_WR_ACK: begin
               if (scl_fall) begin
                  nxt_drive_low = 1'b0;
                  nxt_state     = ST_WR;
               end
            end
            ST_RD_BIT: begin
               if (scl_fall) begin
                  if (bit_cnt_ff == 4'h8) begin
                     nxt_drive_low = 1'b0;
                     nxt_bit_cnt   = 4'h0;
                     nxt_state     = ST_RD_ACK;
                  end else begin
                     nxt_drive_low = ~shift_ff[6];
                     nxt_shift     = {shift_ff[6:0], 1'b0};
                     nxt_bit_cnt   = bit_cnt_ff + 4'h1;
                  end
               end
            end
            ST_RD_ACK: begin
               // host answers on the ninth clock; a nack ends the burst
               if (scl_rise)
                  nxt_state = sda_s ? ST_IDLE : ST_RD_NEXT;
            end
            ST_RD_NEXT: begin
               if (scl_fall) begin
                  nxt_bit_cnt = 4'h1;
                  nxt_state   = ST_RD_BIT;
                  if (byte_idx_ff == 2'd2) begin
                     // next word is sampled when its first byte leaves
                     nxt_ptr       = ptr_inc;
                     nxt_byte_idx  = 2'd0;
                     nxt_out_word  = next_word;
                     nxt_shift     = next_word[23:16];
                     nxt_drive_low = ~next_word[23];
                  end else begin
                     nxt_byte_idx  = byte_idx_ff + 2'd1;
                     nxt_shift     = pick_byte(out_word_ff, byte_idx_ff + 2'd1);
                     nxt_drive_low = ~nxt_shift[7];
                  end
               end
            end
            default: begin
               nxt_state = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_ff     <= ST_IDLE;
         bit_cnt_ff   <= 4'h0;
         shift_ff     <= 8'h00;
         byte_idx_ff  <= 2'd0;
         ptr_ff       <= 8'h00;
         rw_ff        <= 1'b0;
         wdata_ff     <= 16'h0000;
         out_word_ff  <= 24'h000000;
         drive_low_ff <= 1'b0;
         loaded_ff    <= 1'b0;
         for (int i = 0; i < `MCRB_SHADOW_COUNT; i++) begin
            shadow_ff[i] <= 17'h00000;
         end
         user_ff[0]   <= 16'(`MCRB_NV6_RST);
         user_ff[1]   <= 16'(`MCRB_NV7_RST);
      end else begin
         state_ff     <= nxt_state;
         bit_cnt_ff   <= nxt_bit_cnt;
         shift_ff     <= nxt_shift;
         byte_idx_ff  <= nxt_byte_idx;
         ptr_ff       <= nxt_ptr;
         rw_ff        <= nxt_rw;
         wdata_ff     <= nxt_wdata;
         out_word_ff  <= nxt_out_word;
         drive_low_ff <= nxt_drive_low;
         loaded_ff    <= nxt_loaded;
         for (int i = 0; i < `MCRB_SHADOW_COUNT; i++) begin
            shadow_ff[i] <= nxt_shadow[i];
         end
         user_ff[0]   <= nxt_user[0];
         user_ff[1]   <= nxt_user[1];
      end
   end

   // open drain: the line is only ever pulled low
   assign sda_out    = 1'b0;
   assign sda_oe_out = drive_low_ff;
   assign loaded_out = loaded_ff;

   // field decode straight off the shadow flip-flops
   always_comb begin
      cfg_out.pulse_input_band_sel    = shadow_ff[0][`MCRB_BAND_BIT];
      cfg_out.phase_seq_abc           = shadow_ff[0][`MCRB_PHASE_BIT];
      cfg_out.accel_fine_range        = shadow_ff[0][`MCRB_ACCEL_RANGE_BIT];
      cfg_out.demand_clock_source     =
         shadow_ff[0][`MCRB_DEMAND_CLK_HI:`MCRB_DEMAND_CLK_LO];
      cfg_out.max_app_speed           = shadow_ff[0][`MCRB_MAX_SPEED_HI:0];
      cfg_out.startup_accel           = shadow_ff[1][15:0];
      cfg_out.startup_current         =
         shadow_ff[2][`MCRB_START_CUR_HI:`MCRB_START_CUR_LO];
      cfg_out.demand_input_kind       = shadow_ff[2][`MCRB_ANALOG_BIT];
      cfg_out.rated_current           = shadow_ff[2][`MCRB_RATED_CUR_HI:0];
      cfg_out.startup_method          =
         shadow_ff[3][`MCRB_METHOD_HI:`MCRB_METHOD_LO];
      cfg_out.limit_and_buffer_enable = shadow_ff[3][`MCRB_LIMIT_BIT];
      cfg_out.missing_phase_guard     = shadow_ff[3][`MCRB_GUARD_BIT];
      cfg_out.open_loop_drive         = shadow_ff[3][`MCRB_OPEN_DRIVE_BIT];
      cfg_out.tuning_window_open      = shadow_ff[4][`MCRB_TUNE_BIT];
      cfg_out.observer_prop_gain      = shadow_ff[4][`MCRB_GAIN_HI:0];
   end

endmodule

`default_nettype wire

/* File: bench/mcrb_top_asserts.sv */
// concurrent checks on the config bank's pins
`timescale 1ns/100ps
`default_nettype none
`include "mcrb_regs.svh"

module mcrb_top_asserts (
   input wire logic                clk_in,
   input wire logic                rstn_in,
   input wire logic                scl_in,
   input wire logic                sda_in,
   input wire logic                sda_out,
   input wire logic                sda_oe_out,
   input wire logic                loaded_out,
   input wire mcrb_pkg::mcrb_cfg_s cfg_out
);
   import mcrb_pkg::*;
   localparam logic [16:0] NV8  = `MCRB_NV8_RST;
   localparam logic [16:0] NV10 = `MCRB_NV10_RST;
   localparam logic [16:0] NV11 = `MCRB_NV11_RST;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   // open drain: only ever pulls low
   chk_sda_low_only: assert property (sda_out == 1'b0)
      else $error("data line value not low");
   chk_loaded_after_rst: assert property (rstn_in |=> loaded_out)
      else $error("image not loaded one cycle after reset");
   chk_image_at_load: assert property ($rose(loaded_out) |->
      cfg_out.startup_current == NV10[15:13] && cfg_out.max_app_speed == NV8[10:0]
      && cfg_out.limit_and_buffer_enable == NV11[7])
      else $error("fields differ from power-up image");
   chk_quiet_unloaded: assert property (!loaded_out |-> !sda_oe_out)
      else $error("bus driven before image load");
   chk_cfg_scl_low: assert property ($changed(cfg_out) && $past(loaded_out) |->
      !$past(scl_in, 2))
      else $error("config changed outside a clock low phase");
   chk_cfg_then_ack: assert property ($changed(cfg_out) && $past(loaded_out) |->
      ##[0:6] sda_oe_out)
      else $error("config commit without acknowledge");
   chk_oe_stable_high: assert property (scl_in [*4] |=> $stable(sda_oe_out))
      else $error("data drive changed while clock high");
   chk_oe_after_fall: assert property ($rose(sda_oe_out) |-> !$past(scl_in, 2))
      else $error("drive started away from a clock fall");
endmodule

bind mcrb_top mcrb_top_asserts u_chk (
   .clk_in     (clk_in),
   .rstn_in    (rstn_in),
   .scl_in     (scl_in),
   .sda_in     (sda_in),
   .sda_out    (sda_out),
   .sda_oe_out (sda_oe_out),
   .loaded_out (loaded_out),
   .cfg_out    (cfg_out)
);
`default_nettype wire

/* File: bench/mcrb_host.sv */
// two-wire bus controller model that reads and writes the config bank
`timescale 1ns/100ps
`default_nettype none

module mcrb_host #(
   parameter logic [6:0] DEV_ADDR = 7'h2a
) (
   input  wire logic sda_in,
   output var  logic scl_out,
   output var  logic sda_oe_out
);
   logic [23:0] rd_q [0:7];
   // clock idles high between frames; the bus rate is scaled to the bench, not 100 kHz
   initial begin
      scl_out = 1'b1;
      sda_oe_out = 1'b0;
   end
   // sample late in the high phase so the target's delayed drive has settled
   task automatic bit_io(input logic b, output logic r);
      sda_oe_out = ~b;
      #12 scl_out = 1'b1;
      #20 r = sda_in;
      #4 scl_out = 1'b0;
      #12;
   endtask
   task automatic bus_start();
      sda_oe_out = 1'b0;
      #12 scl_out = 1'b1;
      #24 sda_oe_out = 1'b1;
      #24 scl_out = 1'b0;
      #12;
   endtask
   task automatic bus_stop();
      sda_oe_out = 1'b1;
      #12 scl_out = 1'b1;
      #24 sda_oe_out = 1'b0;
      #48;
   endtask
   task automatic byte_io(input logic [7:0] d, input logic ab, output logic [7:0] q,
                          output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
         q[i] = r;
      end
      bit_io(ab, r);
      ack = ~r;
   endtask
   task automatic wr(input logic [7:0] ra, input logic [23:0] d, input int nb,
                     output int nacks);
      logic [7:0] q;
      logic       a;
      nacks = 0;
      bus_start();
      byte_io({DEV_ADDR, 1'b0}, 1'b1, q, a);
      nacks += !a;
      byte_io(ra, 1'b1, q, a);
      nacks += !a;
      for (int i = 0; i < nb; i++) begin
         byte_io(d[23-8*i -: 8], 1'b1, q, a);
         nacks += !a;
      end
      bus_stop();
   endtask
   task automatic rd(input logic [7:0] ra, input int n, output int nacks);
      logic [7:0] q;
      logic       a;
      wr(ra, 24'h0, 0, nacks);
      bus_start();
      byte_io({DEV_ADDR, 1'b1}, 1'b1, q, a);
      nacks += !a;
      for (int r = 0; r < n; r++) begin
         for (int b = 2; b >= 0; b--) begin
            byte_io(8'hff, (r == n - 1) && (b == 0), q, a);
            rd_q[r][8*b +: 8] = q;
         end
      end
      bus_stop();
   endtask
   task automatic probe(input logic [6:0] a7, output logic ack);
      logic [7:0] q;
      bus_start();
      byte_io({a7, 1'b0}, 1'b1, q, ack);
      bus_stop();
   endtask
endmodule
`default_nettype wire

/* File: bench/tb_motor_config_register_bank.sv */
// self-checking bench for the motor config register bank
`timescale 1ns/100ps
`default_nettype none
`include "mcrb_regs.svh"

module tb_motor_config_register_bank;
   import mcrb_pkg::*;
   typedef struct packed {logic [7:0] ra; logic [23:0] d;} mcrb_row_s;
   // value is arbitrary
   localparam logic [6:0] TGT_ADDR = 7'h2a;
   localparam mcrb_row_s ROWS [13] = '{'{8'h48, 24'h12c155}, '{8'h48, 24'h002aaa},
      '{8'h48, 24'h0017ff}, '{8'h48, 24'h001800}, '{8'h49, 24'h00beef},
      '{8'h4a, 24'h00e8ff}, '{8'h4a, 24'h002123}, '{8'h4b, 24'h000098},
      '{8'h4b, 24'h000400}, '{8'h4b, 24'h000800}, '{8'h4b, 24'h000c00},
      '{8'h4c, 24'h01001f}, '{8'h4c, 24'h000011}};
   localparam logic [7:0] LOCKED [4] = '{8'h00, 8'h05, 8'h1f, 8'h45};
   logic        clk_in;
   logic        rstn_in;
   logic        scl;
   logic        sda;
   logic        host_oe;
   logic        sda_out;
   logic        sda_oe_out;
   logic        loaded_out;
   logic        ack;
   mcrb_cfg_s   cfg_out;
   logic [16:0] sh [72:76];
   int          failures;
   int          samples_checked;
   int          nk;

   // pulled-up wire: low whenever either party drives
   assign sda = ~(host_oe | sda_oe_out);

   mcrb_top #(
      .DEV_ADDR   (TGT_ADDR)
   ) dut (
      .clk_in     (clk_in),
      .rstn_in    (rstn_in),
      .scl_in     (scl),
      .sda_in     (sda),
      .sda_out    (sda_out),
      .sda_oe_out (sda_oe_out),
      .loaded_out (loaded_out),
      .cfg_out    (cfg_out)
   );
   mcrb_host #(
      .DEV_ADDR   (TGT_ADDR)
   ) host (
      .sda_in     (sda),
      .scl_out    (scl),
      .sda_oe_out (host_oe)
   );

   function automatic mcrb_cfg_s exp_cfg();
      mcrb_cfg_s c;
      c.pulse_input_band_sel = sh[72][15];
      c.phase_seq_abc = sh[72][14];
      c.accel_fine_range = sh[72][13];
      c.demand_clock_source = sh[72][12:11];
      c.max_app_speed = sh[72][10:0];
      c.startup_accel = sh[73][15:0];
      c.startup_current = sh[74][15:13];
      c.demand_input_kind = sh[74][11];
      c.rated_current = sh[74][10:0];
      c.startup_method = sh[75][11:10];
      c.limit_and_buffer_enable = sh[75][7];
      c.missing_phase_guard = sh[75][4];
      c.open_loop_drive = sh[75][3];
      c.tuning_window_open = sh[76][16];
      c.observer_prop_gain = sh[76][4:0];
      return c;
   endfunction

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("checks=%0d failures=%0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic do_reset(input int n);
      @(negedge clk_in) rstn_in = 1'b0;
      repeat (n) @(negedge clk_in);
      check(cfg_out, 64'h0);
      check(sda_oe_out, 1'b0);
      rstn_in = 1'b1;
      sh[72] = `MCRB_NV8_RST;
      sh[73] = `MCRB_NV9_RST;
      sh[74] = `MCRB_NV10_RST;
      sh[75] = `MCRB_NV11_RST;
      sh[76] = `MCRB_NV12_RST;
      // give the target a few microseconds before the first frame
      repeat (600) @(negedge clk_in);
      check(loaded_out, 1'b1);
      check(cfg_out, exp_cfg());
   endtask

   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end

   initial begin
      #400000;
      failures++;
      summarize();
   end

   initial begin
      rstn_in = 1'b0;
      failures = 0;
      samples_checked = 0;
      do_reset(12);
      foreach (ROWS[i]) begin
         host.wr(ROWS[i].ra, ROWS[i].d, 3, nk);
         check(nk, 0);
         sh[ROWS[i].ra] = ROWS[i].d[16:0] & (ROWS[i].ra == 8'h4c ? `MCRB_WIDE_MASK :
                                             `MCRB_WORD_MASK);
         check(cfg_out, exp_cfg());
         host.rd(ROWS[i].ra, 1, nk);
         check(host.rd_q[0], sh[ROWS[i].ra]);
      end
      host.rd(8'h48, 5, nk);
      check(nk, 0);
      for (int r = 0; r < 5; r++) begin
         check(host.rd_q[r], sh[72 + r]);
      end
      // a frame cut short after two data bytes must leave the word alone
      host.wr(8'h48, 24'h00ffff, 2, nk);
      check(cfg_out, exp_cfg());
      foreach (LOCKED[i]) begin
         host.wr(LOCKED[i], 24'h00ffff, 3, nk);
         host.rd(LOCKED[i], 1, nk);
         check(host.rd_q[0], 24'h0);
      end
      host.wr(8'h06, 24'h001234, 3, nk);
      host.wr(8'h07, 24'h00abcd, 3, nk);
      host.rd(8'h06, 2, nk);
      check(host.rd_q[0], 24'h001234);
      check(host.rd_q[1], 24'h00abcd);
      check(cfg_out, exp_cfg());
      host.probe(TGT_ADDR ^ 7'h01, ack);
      check(ack, 1'b0);
      host.probe(TGT_ADDR, ack);
      check(ack, 1'b1);
      do_reset(3);
      summarize();
   end
endmodule
`default_nettype wire
